// >>> core/smis_edge.sv
// Rising-edge pulse generator for the filtered event levels
`timescale 1ns/1ps
module smis_edge (
  // Clock and control
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Levels in, one-cycle pulses out
  input wire logic [smis_pkg::FLAG_W-1:0] level_in,
  output logic [smis_pkg::FLAG_W-1:0] rise_out
);
  import smis_pkg::*;

  typedef struct packed {
    logic [FLAG_W-1:0] prev;
    logic [FLAG_W-1:0] rise;
  } smis_edge_s;

  smis_edge_s st_ff;
  smis_edge_s nxt_st;

  always_comb begin
    nxt_st.prev = level_in;
    nxt_st.rise = level_in & ~st_ff.prev;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

  assign rise_out = st_ff.rise;

endmodule // smis_edge

// >>> core/smis_pkg.sv
// Constants, types and register map of the masked interrupt status block
// ==========================================================================
package smis_pkg;

  // ========================================================================
  // Flag layout
  localparam int FLAG_W = 7;
  localparam int BIT_PLL_LOCK = 6;
  localparam int BIT_CUR_LIMIT = 5;
  localparam int BIT_INT_OSC = 4;
  localparam int BIT_MAIN_OSC = 3;
  localparam int BIT_REG_UNREG = 2;
  localparam int BIT_BROWNOUT = 1;
  localparam int BIT_PLL_FAULT = 0;
  localparam int BIT_BOR_RESET_SEL = 0;

  // Events that count on their rising edge; the regulator one is a level
  localparam logic [6:0] EDGE_EVENTS = 7'h7B;

  // ========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_BOR_CTRL = 12'h030;
  localparam logic [11:0] OFS_RAW_STATUS = 12'h050;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h054;
  localparam logic [11:0] OFS_MASKED_CLEAR = 12'h058;

  // ========================================================================
  // Reset values
  localparam logic [6:0] RST_RAW = 7'h00;
  localparam logic [6:0] RST_MASK = 7'h00;
  localparam logic RST_BOR_SEL = 1'b0;

  typedef enum logic [2:0] {
    SMIS_REG_NONE,
    SMIS_REG_BOR_CTRL,
    SMIS_REG_RAW,
    SMIS_REG_MASK,
    SMIS_REG_MASKED
  } smis_reg_e;

  // AHB-Lite request from the master side
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } smis_ahb_req_s;

  // AHB-Lite response of this slave
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } smis_ahb_rsp_s;

endpackage

// >>> core/smis_sync.sv
// Three-flop synchroniser with agreement filter for the raw event pins
`timescale 1ns/1ps
module smis_sync (
  // Clock and control
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Asynchronous levels in, filtered levels out
  input wire logic [smis_pkg::FLAG_W-1:0] async_in,
  output logic [smis_pkg::FLAG_W-1:0] level_out
);
  import smis_pkg::*;

  typedef struct packed {
    logic [FLAG_W-1:0] s1;
    logic [FLAG_W-1:0] s2;
    logic [FLAG_W-1:0] s3;
    logic [FLAG_W-1:0] level;
  } smis_sync_s;

  smis_sync_s st_ff;
  smis_sync_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // Only a value seen twice in a row is taken, so glitches drop out
    for (int i = 0; i < FLAG_W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.level[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.level;

endmodule // smis_sync

// >>> core/smis_top.sv
// Masked interrupt status and clear block with its AHB-Lite register slave
`timescale 1ns/1ps
module smis_top (
  // Clock, reset and clock enable
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Register bus
  input smis_pkg::smis_ahb_req_s ahb_req_in,
  output smis_pkg::smis_ahb_rsp_s ahb_rsp_out,
  // Raw event sources, asynchronous levels
  input wire logic pll_ready_in,
  input wire logic cur_limit_in,
  input wire logic int_osc_fault_in,
  input wire logic main_osc_fault_in,
  input wire logic reg_unreg_in,
  input wire logic brownout_in,
  input wire logic pll_fault_in,
  // Interrupt and brown-out reset request
  output logic irq_out,
  output logic bor_reset_req_out
);
  import smis_pkg::*;

  // ========================================================================
  // State
  typedef struct packed {
    logic [FLAG_W-1:0] raw;
    logic [FLAG_W-1:0] mask;
    logic bor_sel;
    logic irq;
    logic bor_req;
    logic wr_pend;
    smis_reg_e wr_reg;
    logic [31:0] rdata;
  } smis_state_s;

  smis_state_s st_ff;
  smis_state_s nxt_st;

  logic [FLAG_W-1:0] evt_async;
  logic [FLAG_W-1:0] evt_level;
  logic [FLAG_W-1:0] evt_rise;
  logic [FLAG_W-1:0] evt_set;
  logic [FLAG_W-1:0] clr;
  logic [FLAG_W-1:0] masked_nxt;
  logic addr_ok;
  smis_reg_e addr_reg;

  // ========================================================================
  // Helpers
  function automatic smis_reg_e reg_decode(input logic [31:0] addr);
    if (addr[31:12] != 20'h00000) begin
      reg_decode = SMIS_REG_NONE;
    end else if (addr[11:0] == OFS_BOR_CTRL) begin
      reg_decode = SMIS_REG_BOR_CTRL;
    end else if (addr[11:0] == OFS_RAW_STATUS) begin
      reg_decode = SMIS_REG_RAW;
    end else if (addr[11:0] == OFS_IRQ_MASK) begin
      reg_decode = SMIS_REG_MASK;
    end else if (addr[11:0] == OFS_MASKED_CLEAR) begin
      reg_decode = SMIS_REG_MASKED;
    end else begin
      reg_decode = SMIS_REG_NONE;
    end
  endfunction

  // Brown-out never reaches the masked view while it is routed to reset
  function automatic logic [FLAG_W-1:0] masked_view(
    input logic [FLAG_W-1:0] raw,
    input logic [FLAG_W-1:0] mask,
    input logic bor_sel
  );
    logic [FLAG_W-1:0] gate;
    gate = mask;
    gate[BIT_BROWNOUT] = mask[BIT_BROWNOUT] & ~bor_sel;
    masked_view = raw & gate;
  endfunction

  // ========================================================================
  // Event inputs
  assign evt_async[BIT_PLL_LOCK] = pll_ready_in;
  assign evt_async[BIT_CUR_LIMIT] = cur_limit_in;
  assign evt_async[BIT_INT_OSC] = int_osc_fault_in;
  assign evt_async[BIT_MAIN_OSC] = main_osc_fault_in;
  assign evt_async[BIT_REG_UNREG] = reg_unreg_in;
  assign evt_async[BIT_BROWNOUT] = brownout_in;
  assign evt_async[BIT_PLL_FAULT] = pll_fault_in;

  smis_sync u_sync (
    .clk_sys_in (clk_sys_in),
    .nrst_in (nrst_in),
    .ce_in (ce_in),
    .async_in (evt_async),
    .level_out (evt_level)
  );

  smis_edge u_edge (
    .clk_sys_in (clk_sys_in),
    .nrst_in (nrst_in),
    .ce_in (ce_in),
    .level_in (evt_level),
    .rise_out (evt_rise)
  );

  // Edge events fire once per assertion; the regulator keeps setting
  // its flag as long as the output stays unregulated
  assign evt_set = (evt_rise & EDGE_EVENTS) |
                   (evt_level & ~EDGE_EVENTS);

  // ========================================================================
  // Bus address phase
  assign addr_ok = ahb_req_in.hsel & ahb_req_in.htrans[1] &
                   ahb_req_in.hready;
  assign addr_reg = reg_decode(ahb_req_in.haddr);

  // Write-one-to-clear strobes of the masked register, data phase
  always_comb begin
    clr = '0;
    if (st_ff.wr_pend && (st_ff.wr_reg == SMIS_REG_MASKED)) begin
      clr = ahb_req_in.hwdata[FLAG_W-1:0];
    end
  end

  // ========================================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr_pend = 1'b0;

    // Data-phase writes; bits above the flag field are dropped
    if (st_ff.wr_pend) begin
      case (st_ff.wr_reg)
        SMIS_REG_MASK: begin
          nxt_st.mask = ahb_req_in.hwdata[FLAG_W-1:0];
        end
        SMIS_REG_BOR_CTRL: begin
          nxt_st.bor_sel = ahb_req_in.hwdata[BIT_BOR_RESET_SEL];
        end
        default: begin
        end
      endcase
    end

    // Clear also hits the raw bit; a new event in the same cycle wins
    nxt_st.raw = (st_ff.raw & ~clr) | evt_set;

    masked_nxt = masked_view(nxt_st.raw, nxt_st.mask, nxt_st.bor_sel);
    nxt_st.irq = |masked_nxt;
    nxt_st.bor_req = evt_level[BIT_BROWNOUT] & nxt_st.bor_sel;

    // Read data taken from the post-write state so back-to-back
    // write then read returns the new value
    if (addr_ok) begin
      nxt_st.wr_pend = ahb_req_in.hwrite;
      nxt_st.wr_reg = addr_reg;
      nxt_st.rdata = 32'h00000000;
      if (!ahb_req_in.hwrite) begin
        case (addr_reg)
          SMIS_REG_RAW: begin
            nxt_st.rdata[FLAG_W-1:0] = nxt_st.raw;
          end
          SMIS_REG_MASK: begin
            nxt_st.rdata[FLAG_W-1:0] = nxt_st.mask;
          end
          SMIS_REG_MASKED: begin
            nxt_st.rdata[FLAG_W-1:0] = masked_nxt;
          end
          SMIS_REG_BOR_CTRL: begin
            nxt_st.rdata[BIT_BOR_RESET_SEL] = nxt_st.bor_sel;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_ff.raw <= RST_RAW;
      st_ff.mask <= RST_MASK;
      st_ff.bor_sel <= RST_BOR_SEL;
      st_ff.irq <= 1'b0;
      st_ff.bor_req <= 1'b0;
      st_ff.wr_pend <= 1'b0;
      st_ff.wr_reg <= SMIS_REG_NONE;
      st_ff.rdata <= 32'h00000000;
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

  // ========================================================================
  // Outputs; zero wait states, always OKAY
  assign ahb_rsp_out.hrdata = st_ff.rdata;
  assign ahb_rsp_out.hreadyout = 1'b1;
  assign ahb_rsp_out.hresp = 1'b0;
  assign irq_out = st_ff.irq;
  assign bor_reset_req_out = st_ff.bor_req;

endmodule // smis_top

// >>> tb/smis_assertions.sv
// Port-level checks of the masked status block
`timescale 1ns/1ps
module smis_chk (
  // Clock and control
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Register bus
  input smis_pkg::smis_ahb_req_s ahb_req_in,
  input smis_pkg::smis_ahb_rsp_s ahb_rsp_out,
  // Raw events
  input wire logic pll_ready_in,
  input wire logic cur_limit_in,
  input wire logic int_osc_fault_in,
  input wire logic main_osc_fault_in,
  input wire logic reg_unreg_in,
  input wire logic brownout_in,
  input wire logic pll_fault_in,
  // Outputs
  input wire logic irq_out,
  input wire logic bor_reset_req_out
);
  import smis_pkg::*;
  logic [6:0] ev;
  logic tk;
  logic w58;
  logic [3:0] quiet_ff;
  logic [3:0] bq_ff;
  logic wr_dp_ff;
  assign ev = {pll_ready_in, cur_limit_in, int_osc_fault_in,
    main_osc_fault_in, reg_unreg_in, brownout_in, pll_fault_in};
  assign tk = ahb_req_in.hsel && ahb_req_in.htrans[1] && ahb_req_in.hready;
  assign w58 = tk && ahb_req_in.hwrite &&
    ahb_req_in.haddr == {20'h0, OFS_MASKED_CLEAR};
  // Counters saturate so that long idle spells stay recognisable
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      quiet_ff <= 4'h0;
      bq_ff <= 4'h0;
      wr_dp_ff <= 1'b0;
    end else begin
      quiet_ff <= (ev != 7'h00) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
      bq_ff <= brownout_in ? 4'h0 : bq_ff + {3'h0, bq_ff != 4'hF};
      wr_dp_ff <= tk && ahb_req_in.hwrite;
    end
  end
  // ==========================================================================
  // Assertions
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  a_rsvd_zero: assert property (ahb_rsp_out.hrdata[31:7] == 25'h0)
    else $error("reserved read bits not zero");
  a_unmapped_zero: assert property (tk && !ahb_req_in.hwrite &&
    ahb_req_in.haddr[31:12] != 20'h0 |=> ahb_rsp_out.hrdata == 32'h0)
    else $error("unmapped read not zero");
  // A write lands at the end of its data phase, so its effect on irq_out
  // is seen one edge after wr_dp_ff is high
  a_irq_rise: assert property ($rose(irq_out) |->
    quiet_ff < 4'hC || $past(wr_dp_ff))
    else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(irq_out) |-> $past(wr_dp_ff))
    else $error("irq fell without a clear");
  a_clear_all: assert property (w58 ##1 (ahb_req_in.hwdata[6:0] ==
    7'h7F && quiet_ff > 4'h7) |=> !irq_out) else $error("irq kept");
  a_zero_keeps: assert property (w58 ##1 (ahb_req_in.hwdata[6:0] ==
    7'h00 && quiet_ff > 4'h7 && irq_out) |=> irq_out)
    else $error("zero write cleared");
  a_bor_quiet: assert property (bq_ff > 4'h7 |-> !bor_reset_req_out)
    else $error("brownout reset request without brownout");
  a_irq_reset: assert property (disable iff (1'b0)
    !nrst_in && ce_in |=> !irq_out && !bor_reset_req_out)
    else $error("outputs high after reset");
  c_irq: cover property ($rose(irq_out));
  c_bor: cover property ($rose(bor_reset_req_out));
  c_clear: cover property (w58 ##1 1'b1 ##1 $fell(irq_out));
endmodule // smis_chk

bind smis_top smis_chk chk_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
  .ce_in(ce_in), .ahb_req_in(ahb_req_in), .ahb_rsp_out(ahb_rsp_out),
  .pll_ready_in(pll_ready_in), .cur_limit_in(cur_limit_in),
  .int_osc_fault_in(int_osc_fault_in), .main_osc_fault_in(main_osc_fault_in),
  .reg_unreg_in(reg_unreg_in), .brownout_in(brownout_in),
  .pll_fault_in(pll_fault_in), .irq_out(irq_out),
  .bor_reset_req_out(bor_reset_req_out));

// >>> tb/smis_events.sv
// Raw event sources standing at the far side of the status block
`timescale 1ns/1ps
module smis_events (
  // Clock
  input wire logic clk_sys_in,
  // Requested event levels, launched one cycle later
  input wire logic [6:0] fire_in,
  output logic [6:0] ev_out
);
  always_ff @(posedge clk_sys_in) begin
    ev_out <= fire_in;
  end
endmodule // smis_events

// >>> tb/tb.sv
// Self-checking bench for the masked status block
`timescale 1ns/1ps
module tb;
  import smis_pkg::*;
  localparam logic [31:0] BC = {20'h0, OFS_BOR_CTRL};
  localparam logic [31:0] RAW = {20'h0, OFS_RAW_STATUS};
  localparam logic [31:0] MSK = {20'h0, OFS_IRQ_MASK};
  localparam logic [31:0] MC = {20'h0, OFS_MASKED_CLEAR};
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce = 1'b1;
  smis_ahb_req_s m = '0;
  smis_ahb_req_s req;
  smis_ahb_rsp_s rsp;
  logic [6:0] fire = 7'h00;
  logic [6:0] ev;
  logic irq;
  logic bor;
  logic [31:0] rdat;
  int errors = 0;
  int samples_checked = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  // The single slave's hreadyout is the bus hready
  always_comb begin
    req = m;
    req.hready = rsp.hreadyout;
  end
  smis_events src (.clk_sys_in(clk_sys_in), .fire_in(fire), .ev_out(ev));
  smis_top dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(ce),
    .ahb_req_in(req), .ahb_rsp_out(rsp), .pll_ready_in(ev[6]),
    .cur_limit_in(ev[5]), .int_osc_fault_in(ev[4]),
    .main_osc_fault_in(ev[3]), .reg_unreg_in(ev[2]), .brownout_in(ev[1]),
    .pll_fault_in(ev[0]), .irq_out(irq), .bor_reset_req_out(bor));
  // ==========================================================================
  // Tasks
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic hrdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (rsp.hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      close_out();
    end
  endtask
  task automatic xfer(logic [31:0] a, logic w, logic [31:0] d);
    m <= '{1'b1, a, 2'h2, w, 3'h2, m.hwdata, 1'b1};
    hrdy();
    m <= '{1'b0, a, 2'h0, w, 3'h2, d, 1'b1};
    hrdy();
    rdat = rsp.hrdata;
  endtask
  task automatic rdc(logic [31:0] a, logic [31:0] e, string nm);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, rdat);
    chk("hresp", 32'h0, {31'h0, rsp.hresp});
  endtask
  task automatic ci(logic ei, logic eb);
    @(negedge clk_sys_in);
    chk("irq", {31'h0, ei}, {31'h0, irq});
    chk("bor_req", {31'h0, eb}, {31'h0, bor});
    @(posedge clk_sys_in);
  endtask
  task automatic pulse(logic [6:0] b);
    fire <= b;
    repeat (10) @(posedge clk_sys_in);
    fire <= 7'h00;
    repeat (10) @(posedge clk_sys_in);
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (12) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rdc(BC, 32'h0, "ctrl");
    rdc(RAW, 32'h0, "raw");
    rdc(MSK, 32'h0, "mask");
    rdc(MC, 32'h0, "masked");
    for (int i = 0; i < 7; i++) begin
      xfer(MSK, 1'b1, 32'h1 << i);
      pulse(7'h01 << i);
      rdc(MC, 32'h1 << i, "flag");
      rdc(MC, 32'h1 << i, "flag");
      ci(1'b1, 1'b0);
      xfer(MC, 1'b1, 32'h0);
      rdc(MC, 32'h1 << i, "kept");
      xfer(MC, 1'b1, 32'h1 << i);
      rdc(RAW, 32'h0, "raw");
      ci(1'b0, 1'b0);
    end
    xfer(MSK, 1'b1, 32'h0);
    pulse(7'h7F);
    rdc(RAW, 32'h7F, "raw");
    rdc(MC, 32'h0, "masked");
    ci(1'b0, 1'b0);
    xfer(MSK, 1'b1, 32'hFFFFFFFF);
    rdc(MSK, 32'h7F, "mask");
    xfer(BC, 1'b1, 32'h1);
    rdc(MC, 32'h7D, "sel");
    xfer(MC, 1'b1, 32'h7D);
    ci(1'b0, 1'b0);
    xfer(MC, 1'b1, 32'h7F);
    fire <= 7'h02;
    repeat (10) @(posedge clk_sys_in);
    ci(1'b0, 1'b1);
    pulse(7'h00);
    rdc(RAW, 32'h2, "raw");
    // An event that comes and goes while the clock enable is low is lost
    ce <= 1'b0;
    pulse(7'h40);
    ce <= 1'b1;
    rdc(RAW, 32'h2, "frozen");
    ci(1'b0, 1'b0);
    rdc(32'h00010050, 32'h0, "unmapped");
    close_out();
  end
endmodule // tb
